// ### rtl/svlm_pkg.sv
// Package with lane map, strap levels and FIFO shape for the serial video lane mux.
package svlm_pkg;

  // Lane counts of the shared graphics port.
  localparam int unsigned LANES      = 16;
  localparam int unsigned LANE_W     = 4;
  localparam int unsigned LAST_LANE  = 15;

  // Transmit lane indices in the unreversed video-only arrangement.
  localparam logic [3:0] TX_B_RED    = 4'h0;
  localparam logic [3:0] TX_B_GREEN  = 4'h1;
  localparam logic [3:0] TX_B_BLUE   = 4'h2;
  localparam logic [3:0] TX_B_CLOCK  = 4'h3;
  localparam logic [3:0] TX_C_RED    = 4'h4;
  localparam logic [3:0] TX_C_GREEN  = 4'h5;
  localparam logic [3:0] TX_C_BLUE   = 4'h6;
  localparam logic [3:0] TX_C_CLOCK  = 4'h7;

  // Receive lane indices in the unreversed video-only arrangement.
  localparam logic [3:0] RX_TV_CLOCK = 4'h0;
  localparam logic [3:0] RX_B_IRQ    = 4'h1;
  localparam logic [3:0] RX_STALL    = 4'h2;
  localparam logic [3:0] RX_C_IRQ    = 4'h5;

  // Strap levels.
  localparam logic STRAP_REVERSED    = 1'b0;
  localparam logic STRAP_CONCURRENT  = 1'b1;

  // Video stream FIFO shape.
  localparam int unsigned PIX_W      = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  // Reset values.
  localparam logic [15:0] LANES_RST  = 16'h0000;

  // Lane arrangement chosen by straps.
  typedef enum logic [1:0] {
    SVLM_VID_NORMAL,
    SVLM_VID_REVERSED,
    SVLM_CONC_NORMAL,
    SVLM_CONC_REVERSED
  } svlm_cfg_t;

endpackage

// ### rtl/svlm_fifo.sv
// Parameterised valid/ready FIFO for the serial video word stream.
`timescale 1ns/1ps
module svlm_fifo
  import svlm_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)(
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;
  logic [AW:0]      count_d;
  logic             ready_q;

  // Ready is a flop fed from the next count, so the writer sees a clean
  // registered signal and the full boundary is still exact.
  assign wr_ready_out = ready_q;

  // Next occupancy; a push and a pop in one cycle leave it unchanged.
  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = count_q + 1'b1;
    end
    else if (pop && !push)
    begin
      count_d = count_q - 1'b1;
    end
  end
  assign rd_valid_out = (count_q != '0);
  assign rd_data_out  = mem_q[rd_ptr_q];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  // Storage is written without reset; only the pointers, count and ready flag need a defined state.
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      ready_q <= (count_d < (AW+1)'(DEPTH));
    end
  end

endmodule // svlm_fifo

// ### rtl/svlm_lane_mux.sv
// Serial video lane mux: steers two video channels and sideband inputs onto graphics port lanes.
//
// Behaviour
// RULE1 - Video outputs and sideband inputs travel on the same differential lanes as the graphics port.
// RULE2 - The control clock and data pins are dedicated and never pass through the lane mux.
// RULE3 - Unreversed video-only puts B red/green/blue/clock on tx 0-3, C on tx 4-7, sidebands on rx 0,1,2,5.
// RULE4 - Reversed video-only and concurrent-normal move lane n to 15-n; concurrent-reversed is unreversed.
// RULE5 - Each video signal leaves as a true line and its complement.
// RULE6 - The channel C red pair may carry channel B alpha instead of channel C red.
// RULE7 - The encoder supplies the TV sync clock on the receive pair the configuration assigns.
// RULE8 - The encoder signals channel B and channel C interrupts on separate receive pairs.
// RULE9 - The encoder drives field stall on its assigned receive pair so delivery can pause.
// RULE10 - Both sides drive the control clock and data lines only low and otherwise release them.
// RULE11 - A low lane-reversal strap selects reversed lane numbering, high selects normal numbering.
// RULE12 - The board holds the concurrent-select strap low; the high setting is reserved.
// RULE13 - Straps are sampled during reset and the lane assignment holds until the next reset.
`timescale 1ns/1ps
module svlm_lane_mux
  import svlm_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              lane_reverse_strap_in,
  input  wire logic              concurrent_select_strap_in,
  input  wire logic              video_enable_in,
  input  wire logic              b_alpha_select_in,
  input  wire logic [PIX_W-1:0]  pix_data_in,
  input  wire logic              pix_valid_in,
  output logic                   pix_ready_out,
  input  wire logic [LANES-1:0]  gfx_port_tx_lane_in,
  output logic [LANES-1:0]       gfx_port_tx_lane_out,
  output logic [LANES-1:0]       gfx_port_tx_lane_n_out,
  input  wire logic [LANES-1:0]  gfx_port_rx_lane_in,
  output logic [LANES-1:0]       gfx_port_rx_lane_out,
  output logic                   tv_sync_clock_out,
  output logic                   tv_sync_edge_out,
  output logic                   chan_b_irq_out,
  output logic                   chan_c_irq_out,
  output logic                   field_stall_out,
  output logic [1:0]             lane_cfg_out,
  input  wire logic              ctl_bus_clock_in,
  output logic                   ctl_bus_clock_out,
  output logic                   ctl_bus_clock_oe_n_out,
  input  wire logic              ctl_bus_data_in,
  output logic                   ctl_bus_data_out,
  output logic                   ctl_bus_data_oe_n_out,
  input  wire logic              ctl_clock_drive_low_in,
  input  wire logic              ctl_data_drive_low_in,
  output logic                   ctl_bus_clock_sync_out,
  output logic                   ctl_bus_data_sync_out
);

  // Map a lane index through the reversal choice.
  function automatic logic [3:0] lane_of(input logic [3:0] idx, input logic rev);
    lane_of = rev ? 4'(LAST_LANE - idx) : idx;
  endfunction

  logic             rst_seen_q;
  logic             strap_rev_q;
  logic             strap_conc_q;
  logic             map_rev_q;
  logic [LANES-1:0] rx_meta_q;
  logic [LANES-1:0] rx_sync_q;
  logic [1:0]       ctl_meta_q;
  logic [1:0]       ctl_sync_q;
  logic             tv_prev_q;
  logic [PIX_W-1:0] fifo_data;
  logic             fifo_valid;
  logic             fifo_ready;
  logic [PIX_W-1:0] shift_q;
  logic [2:0]       bit_q;
  logic             word_live_q;
  logic             stall_now;
  logic [7:0]       video_bits;
  logic [LANES-1:0] tx_d;
  logic             map_rev_d;
  logic [1:0]       strap_meta_q;
  logic [1:0]       strap_sync_q;

  // Strap pins are asynchronous levels; these two flops run even during
  // reset, so the synced value at release is the one held during reset.
  always_ff @(posedge clk_in)
  begin
    strap_meta_q <= {concurrent_select_strap_in, lane_reverse_strap_in};
    strap_sync_q <= strap_meta_q;
  end

  // The synced straps are taken on the first clock after reset release and
  // never again, so a strap that moves later cannot remap live lanes.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_seen_q   <= 1'b0;
      strap_rev_q  <= 1'b0;
      strap_conc_q <= 1'b0;
      map_rev_q    <= 1'b0;
    end
    else if (!rst_seen_q)
    begin
      rst_seen_q   <= 1'b1;                                           // RULE13
      strap_rev_q  <= (strap_sync_q[0] == STRAP_REVERSED);            // RULE11
      strap_conc_q <= (strap_sync_q[1] == STRAP_CONCURRENT);
      map_rev_q    <= map_rev_d;
    end
  end

  // Reversed video-only and concurrent-normal both use 15-n; the reserved
  // concurrent setting is still decoded so a misstrapped board stays sane.
  assign map_rev_d = (strap_sync_q[1] == STRAP_CONCURRENT)
                   ^ (strap_sync_q[0] == STRAP_REVERSED);             // RULE4

  // Two-flop synchronisers for every receive lane and both control pins.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rx_meta_q  <= LANES_RST;
      rx_sync_q  <= LANES_RST;
      ctl_meta_q <= 2'h3;
      ctl_sync_q <= 2'h3;
    end
    else
    begin
      rx_meta_q  <= gfx_port_rx_lane_in;
      rx_sync_q  <= rx_meta_q;
      ctl_meta_q <= {ctl_bus_data_in, ctl_bus_clock_in};
      ctl_sync_q <= ctl_meta_q;
    end
  end

  // The output FIFO absorbs bursts; field stall holds back the serialiser.
  svlm_fifo #(
    .WIDTH (PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .arst_n_in    (arst_n_in),
    .wr_data_in   (pix_data_in),
    .wr_valid_in  (pix_valid_in),
    .wr_ready_out (pix_ready_out),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_ready)
  );

  assign stall_now  = rx_sync_q[lane_of(RX_STALL, map_rev_q)];        // RULE9
  assign fifo_ready = video_enable_in && !stall_now && (!word_live_q || bit_q == 3'h7);

  // Each word goes out one bit per clock on the six colour lanes, C red excepted when alpha is selected; a word
  // completes before stall takes effect so fields are never torn mid-word.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shift_q     <= '0;
      bit_q       <= 3'h0;
      word_live_q <= 1'b0;
    end
    else if (fifo_valid && fifo_ready)
    begin
      shift_q     <= fifo_data;
      bit_q       <= 3'h0;
      word_live_q <= 1'b1;
    end
    else if (word_live_q)
    begin
      bit_q       <= bit_q + 3'h1;
      word_live_q <= (bit_q != 3'h7);
    end
  end

  // Video bits in unreversed order: B red, green, blue, clock, then C.
  always_comb
  begin
    video_bits    = 8'h00;
    video_bits[0] = word_live_q && shift_q[bit_q];
    video_bits[1] = word_live_q && shift_q[bit_q];
    video_bits[2] = word_live_q && shift_q[bit_q];
    video_bits[3] = word_live_q && !bit_q[0];
    video_bits[4] = word_live_q && (b_alpha_select_in ? shift_q[7] : shift_q[bit_q]); // RULE6
    video_bits[5] = word_live_q && shift_q[bit_q];
    video_bits[6] = word_live_q && shift_q[bit_q];
    video_bits[7] = word_live_q && !bit_q[0];
  end

  // Lane steering: with video enabled, video owns the eight mapped lanes and the port keeps the rest; otherwise the port keeps all.
  always_comb
  begin
    tx_d = gfx_port_tx_lane_in;
    if (video_enable_in)
    begin
      for (int i = 0; i < 8; i++)
      begin
        tx_d[lane_of(4'(i), map_rev_q)] = video_bits[i];           // RULE1 RULE3 RULE4
      end
    end
  end

  // Registered differential pairs, true line and complement.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      gfx_port_tx_lane_out   <= LANES_RST;
      gfx_port_tx_lane_n_out <= ~LANES_RST;
    end
    else
    begin
      gfx_port_tx_lane_out   <= tx_d;
      gfx_port_tx_lane_n_out <= ~tx_d;                                // RULE5
    end
  end

  // Sideband inputs are picked from the lanes the configuration assigns.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      gfx_port_rx_lane_out <= LANES_RST;
      tv_sync_clock_out    <= 1'b0;
      tv_prev_q            <= 1'b0;
      tv_sync_edge_out     <= 1'b0;
      chan_b_irq_out       <= 1'b0;
      chan_c_irq_out       <= 1'b0;
      field_stall_out      <= 1'b0;
      lane_cfg_out         <= 2'h0;
    end
    else
    begin
      gfx_port_rx_lane_out <= rx_sync_q;
      tv_sync_clock_out    <= rx_sync_q[lane_of(RX_TV_CLOCK, map_rev_q)]; // RULE7
      tv_prev_q            <= rx_sync_q[lane_of(RX_TV_CLOCK, map_rev_q)];
      tv_sync_edge_out     <= rx_sync_q[lane_of(RX_TV_CLOCK, map_rev_q)] && !tv_prev_q;
      chan_b_irq_out       <= rx_sync_q[lane_of(RX_B_IRQ, map_rev_q)];    // RULE8
      chan_c_irq_out       <= rx_sync_q[lane_of(RX_C_IRQ, map_rev_q)];    // RULE8
      field_stall_out      <= stall_now;
      lane_cfg_out         <= {strap_conc_q, strap_rev_q};
    end
  end

  // Open-drain control pins bypass the mux: output is always low and the
  // enable (active low) opens only to pull the line down.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctl_bus_clock_out      <= 1'b0;
      ctl_bus_clock_oe_n_out <= 1'b1;
      ctl_bus_data_out       <= 1'b0;
      ctl_bus_data_oe_n_out  <= 1'b1;
      ctl_bus_clock_sync_out <= 1'b1;
      ctl_bus_data_sync_out  <= 1'b1;
    end
    else
    begin
      ctl_bus_clock_out      <= 1'b0;                                 // RULE10
      ctl_bus_clock_oe_n_out <= !ctl_clock_drive_low_in;              // RULE2 RULE10
      ctl_bus_data_out       <= 1'b0;
      ctl_bus_data_oe_n_out  <= !ctl_data_drive_low_in;               // RULE2 RULE10
      ctl_bus_clock_sync_out <= ctl_sync_q[0];
      ctl_bus_data_sync_out  <= ctl_sync_q[1];
    end
  end

  // Checks.
  // The configuration output lags the capture by one clock, hence the two-deep look back.
  cfg_held_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE13
    rst_seen_q && $past(rst_seen_q, 2) |-> $stable(map_rev_q) && $stable(lane_cfg_out))
    else $error("Lane configuration changed after capture");
  pair_compl_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE5
    gfx_port_tx_lane_n_out == ~gfx_port_tx_lane_out)
    else $error("Lane complement mismatch");
  b_red_lane_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE3
    video_enable_in && rst_seen_q |=> gfx_port_tx_lane_out[map_rev_q ? 15 : 0] == $past(video_bits[0]))
    else $error("Channel B red on wrong lane");
  c_clock_rev_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE4
    video_enable_in && map_rev_q |=> gfx_port_tx_lane_out[8] == $past(video_bits[7]))
    else $error("Channel C clock not on lane 8 when reversed");
  rev_strap_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE4
    rst_seen_q |-> map_rev_q == (strap_rev_q ^ strap_conc_q))
    else $error("Reversal decode wrong");
  c_irq_pick_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE8
    rst_seen_q |=> chan_c_irq_out == $past(rx_sync_q[map_rev_q ? 10 : 5]))
    else $error("Channel C interrupt taken from wrong lane");
  b_irq_pick_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE8
    rst_seen_q |=> chan_b_irq_out == $past(rx_sync_q[map_rev_q ? 14 : 1]))
    else $error("Channel B interrupt taken from wrong lane");
  tv_pick_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE7
    rst_seen_q |=> tv_sync_clock_out == $past(rx_sync_q[map_rev_q ? 15 : 0]))
    else $error("TV clock taken from wrong lane");
  stall_pick_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE9
    rst_seen_q |=> field_stall_out == $past(rx_sync_q[map_rev_q ? 13 : 2]))
    else $error("Field stall taken from wrong lane");
  stall_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE9
    stall_now && (!word_live_q || bit_q == 3'h7) |=> !word_live_q)
    else $error("Word started during field stall");
  od_low_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RULE10
    rst_seen_q |-> !ctl_bus_clock_out && !ctl_bus_data_out
      && (ctl_bus_clock_oe_n_out == !$past(ctl_clock_drive_low_in))
      && (ctl_bus_data_oe_n_out == !$past(ctl_data_drive_low_in)))
    else $error("Control pin driven high or pulled without request");
  alpha_cov_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) b_alpha_select_in && word_live_q);
  tv_cov_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) tv_sync_edge_out);
  stall_cov_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) stall_now && fifo_valid);
  rev_cov_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) map_rev_q && video_enable_in);

endmodule // svlm_lane_mux

// ### dv/svlm_encoder_model.sv
// Behavioural model of the external serial video encoder on the far side of the lane mux.
`timescale 1ns/1ps
module svlm_encoder_model (
  input  wire logic        rev_in,
  input  wire logic        b_irq_in,
  input  wire logic        c_irq_in,
  input  wire logic        stall_in,
  input  wire logic        tv_run_in,
  input  wire logic        clk_pull_in,
  input  wire logic        data_pull_in,
  output logic [15:0]      rx_lane_out,
  output logic             clk_low_out,
  output logic             data_low_out
);
  logic tv_q;

  // The sync clock stands low outside bursts; the odd offset keeps it unrelated to the mux clock.
  initial
  begin
    tv_q = 1'b0;
    #1.3;
    forever
    begin
      #62.5;
      tv_q = tv_run_in ? ~tv_q : 1'b0;
    end
  end

  // Each sideband sits on its configured lane; reversal moves lane n to lane 15 minus n.
  always_comb
  begin
    rx_lane_out                   = 16'h0000;
    rx_lane_out[rev_in ? 15 : 0]  = tv_q;
    rx_lane_out[rev_in ? 14 : 1]  = b_irq_in;
    rx_lane_out[rev_in ? 10 : 5]  = c_irq_in;
    rx_lane_out[rev_in ? 13 : 2]  = stall_in;
  end

  // Open-drain control lines: the model only ever pulls low, never drives high.
  assign clk_low_out  = clk_pull_in;
  assign data_low_out = data_pull_in;
endmodule // svlm_encoder_model

// ### dv/testbench.sv
// Self-checking testbench for the serial video lane mux with an encoder model on its far side.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        strap_rev, strap_conc, vid_en, alpha_sel, pix_valid, pix_ready;
  logic        m_rev, m_b, m_c, m_stall, m_tv, m_data_pull, m_clk_pull, drv_clk, drv_data;
  logic [7:0]  pix_data;
  logic [15:0] port_tx, tx, tx_n, rx, rx_out;
  logic [1:0]  cfg;
  logic        tv_lvl, tv_edge, b_irq, c_irq, stall, clk_out, clk_oe_n, data_out, data_oe_n;
  logic        clk_sync, data_sync, clk_low, data_low;
  wire         ctl_clk_w  = !clk_low && (clk_oe_n || clk_out);
  wire         ctl_data_w = !data_low && (data_oe_n || data_out);
  int          n_mismatch = 0;
  int          comparisons = 0;

  // Free-running 200 MHz clock.
  always #2.5 clk_in = ~clk_in;

  svlm_lane_mux uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .lane_reverse_strap_in(strap_rev),
    .concurrent_select_strap_in(strap_conc), .video_enable_in(vid_en), .b_alpha_select_in(alpha_sel),
    .pix_data_in(pix_data), .pix_valid_in(pix_valid), .pix_ready_out(pix_ready),
    .gfx_port_tx_lane_in(port_tx), .gfx_port_tx_lane_out(tx), .gfx_port_tx_lane_n_out(tx_n),
    .gfx_port_rx_lane_in(rx), .gfx_port_rx_lane_out(rx_out), .tv_sync_clock_out(tv_lvl),
    .tv_sync_edge_out(tv_edge), .chan_b_irq_out(b_irq), .chan_c_irq_out(c_irq), .field_stall_out(stall),
    .lane_cfg_out(cfg), .ctl_bus_clock_in(ctl_clk_w), .ctl_bus_clock_out(clk_out),
    .ctl_bus_clock_oe_n_out(clk_oe_n), .ctl_bus_data_in(ctl_data_w), .ctl_bus_data_out(data_out),
    .ctl_bus_data_oe_n_out(data_oe_n), .ctl_clock_drive_low_in(drv_clk), .ctl_data_drive_low_in(drv_data),
    .ctl_bus_clock_sync_out(clk_sync), .ctl_bus_data_sync_out(data_sync));

  svlm_encoder_model enc (.rev_in(m_rev), .b_irq_in(m_b), .c_irq_in(m_c), .stall_in(m_stall),
    .tv_run_in(m_tv), .clk_pull_in(m_clk_pull), .data_pull_in(m_data_pull), .rx_lane_out(rx),
    .clk_low_out(clk_low), .data_low_out(data_low));

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Straps are held steady across the release, since they are captured just after it.
  task automatic do_reset(input logic conc, input logic strap);
    @(negedge clk_in);
    arst_n_in  = 1'b0;
    strap_conc = conc;
    strap_rev  = strap;
    m_rev      = conc ^ ~strap;
    repeat (10) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
  endtask

  // Ready only moves at a rising edge, so its value at the falling edge is what that edge samples.
  task automatic push(input logic [7:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      pix_data  = w;
      pix_valid = 1'b1;
      while (pix_ready !== 1'b1) @(negedge clk_in);
      @(negedge clk_in);
    end
    pix_valid = 1'b0;
  endtask

  // Counts ones on a data lane and changes on a clock lane, checking the complement pins each cycle.
  task automatic watch(input int a, input int ck, input int cyc, output int ones, output int tog);
    logic prev;
    int   bad;
    ones = 0;
    tog  = 0;
    bad  = 0;
    prev = tx[ck];
    repeat (cyc)
    begin
      @(negedge clk_in);
      ones += tx[a];
      tog  += (tx[ck] !== prev);
      prev  = tx[ck];
      bad  += (tx_n !== ~tx);
    end
    `CHK("complement lanes", 0, bad)
  endtask

  // Waits a bounded time for the synchronised sidebands, then compares them.
  task automatic settle(input logic [2:0] exp);
    for (int k = 0; k < 10 && {b_irq, c_irq, stall} !== exp; k++) @(negedge clk_in);
    `CHK("sidebands", exp, {b_irq, c_irq, stall})
  endtask

  // One strap setting: sideband lanes, a video word, sync clock edges, and strap changes ignored.
  task automatic t_config(input logic conc, input logic strap);
    int ones, tog, pulses, hi;
    do_reset(conc, strap);
    `CHK("lane config", {conc, ~strap}, cfg)
    for (int i = 0; i < 4; i++)
    begin
      {m_b, m_c, m_stall} = 3'b100 >> i;
      settle(3'b100 >> i);
    end
    push(8'hFF, 1);
    watch(m_rev ? 15 : 0, m_rev ? 12 : 3, 24, ones, tog);
    `CHK("b red ones", 8, ones)
    `CHK("b clock toggling", 1'b1, tog >= 8)
    pulses = 0;
    hi     = 0;
    fork
      begin
        m_tv = 1'b1;
        repeat (3) @(posedge enc.tv_q);
        m_tv = 1'b0;
      end
      repeat (90)
      begin
        @(negedge clk_in);
        pulses += tv_edge;
        hi     += tv_lvl;
      end
    join
    `CHK("tv sync rises", 3, pulses)
    // Three high phases of 62.5 ns each show as 12 or 13 clocks apiece.
    `CHK("tv sync level", 1'b1, hi >= 36 && hi <= 39)
    strap_conc = ~conc;
    strap_rev  = ~strap;
    m_b        = 1'b1;
    settle(3'b100);
    `CHK("concurrent held", conc, cfg[1])
    m_b = 1'b0;
    settle(3'b000);
  endtask

  // Port traffic passes when video is off, and the receive lanes are copied out.
  task automatic t_port();
    vid_en  = 1'b0;
    port_tx = 16'h5AC3;
    m_b     = 1'b1;
    repeat (6) @(negedge clk_in);
    `CHK("port tx", 16'h5AC3, tx)
    `CHK("port tx n", 16'hA53C, tx_n)
    `CHK("port rx", 16'h0002, rx_out)
    port_tx = 16'h0000;
    m_b     = 1'b0;
  endtask

  // Fill the buffer until refused, then drain with the encoder stalling midway.
  task automatic t_fifo();
    int ones, tog;
    push(8'hFF, 16);
    `CHK("buffer full", 1'b0, pix_ready)
    vid_en = 1'b1;
    fork
      watch(0, 3, 200, ones, tog);
      begin
        repeat (30) @(negedge clk_in);
        m_stall = 1'b1;
        repeat (20) @(negedge clk_in);
        m_stall = 1'b0;
      end
    join
    `CHK("drained ones", 128, ones)
    `CHK("buffer empty", 1'b1, pix_ready)
    alpha_sel = 1'b1;
    push(8'h80, 1);
    watch(4, 7, 24, ones, tog);
    `CHK("alpha on c red", 8, ones)
    alpha_sel = 1'b0;
  endtask

  // Control lines only pull low and see the far side pulling too.
  task automatic t_ctl();
    drv_clk = 1'b1;
    repeat (6) @(negedge clk_in);
    `CHK("clock pulled", 6'b000101, {clk_oe_n, clk_out, clk_sync, data_oe_n, data_out, data_sync})
    drv_clk     = 1'b0;
    drv_data    = 1'b1;
    m_data_pull = 1'b1;
    repeat (6) @(negedge clk_in);
    `CHK("data pulled", 4'b1100, {clk_oe_n, clk_sync, data_oe_n, data_sync})
    drv_data   = 1'b0;
    m_clk_pull = 1'b1;
    repeat (6) @(negedge clk_in);
    `CHK("far side low", 4'b1010, {clk_oe_n, clk_sync, data_oe_n, data_sync})
    m_data_pull = 1'b0;
    m_clk_pull  = 1'b0;
  endtask

  // Main sequence.
  initial
  begin
    {strap_conc, alpha_sel, pix_valid, m_rev, m_b, m_c, m_stall, m_tv, m_data_pull, m_clk_pull} = '0;
    {drv_clk, drv_data} = '0;
    strap_rev = 1'b1;
    vid_en    = 1'b1;
    pix_data  = 8'h00;
    port_tx   = 16'h0000;
    for (int c = 0; c < 4; c++) t_config(c[1], c[0]);
    do_reset(1'b0, 1'b1);
    t_port();
    t_fifo();
    t_ctl();
    close_out();
  end

  // Watchdog: the whole run needs roughly 900 cycles.
  initial
  begin
    #50000;
    n_mismatch++;
    close_out();
  end
endmodule // testbench
